// [inc/wdt_regs.svh]
// register indices, field positions, reset values and timing counts of the watchdog
// assumes the includer addresses registers by word index times four
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// register indices, byte address is index times four
`define WDT_IDX_COUNT 8'hFF
`define WDT_IDX_PWR_CTL 8'h87

// power control register fields
`define WDT_PWR_UNLOCK_BIT 4
`define WDT_PWR_PD_BIT 1
`define WDT_PWR_IDLE_BIT 0

// reset values
`define WDT_COUNT_RST 8'h00
`define WDT_PWR_RST 8'h00

// structure and timing counts
`define WDT_CNT_W 8
`define WDT_PRE_W 11
`define WDT_MC_DIV 12
`define WDT_PULSE_MC 3

`endif

// [inc/wdt_pkg.sv]
// types shared by the watchdog modules
// assumes nothing beyond a SystemVerilog elaborator
package wdt_pkg;

   // apb data word
   typedef logic [31:0] apb_word_t;

   // software visible byte
   typedef logic [7:0] reg_byte_t;

   // reset pin pulse sequencer, gray along idle, drive, done
   typedef enum logic [1:0] {
      PL_IDLE = 2'b00,
      PL_DRIVE = 2'b01,
      PL_DONE = 2'b11
   } pulse_state_t;

endpackage

// [inc/wdt_tick_if.sv]
// ticks and strobes passed between the watchdog core, prescaler and pulse stretcher
// assumes one clock and one synchronous reset for all three modules
interface wdt_tick_if (
   input wire logic clk,
   input wire logic srst
);
   logic ce;
   logic run;
   logic mc_tick;
   logic wrap_tick;
   logic fire;
   logic drive;

   modport pre (input clk, srst, ce, run, output mc_tick, wrap_tick);
   modport pulse (input clk, srst, ce, fire, output drive);
   modport core (output ce, run, fire, input mc_tick, wrap_tick, drive);
endinterface

// [logic/wdt_prescale.sv]
// machine cycle divider and prescaler ahead of the watchdog counter
// assumes ce and run come from the core on the same clock
`include "wdt_regs.svh"

module wdt_prescale #(
   parameter int MC_DIV = `WDT_MC_DIV,
   parameter int PRE_W = `WDT_PRE_W
) (
   // tick carrier
   wdt_tick_if.pre tk
);
   import wdt_pkg::*;

   localparam int DIV_W = $clog2(MC_DIV);

   if (MC_DIV < 2 || PRE_W < 1) begin : g_chk
      $error("wdt_prescale: MC_DIV must be at least 2 and PRE_W at least 1");
   end

   logic [DIV_W-1:0] div_q;
   logic [PRE_W-1:0] pre_q;

   // oscillator divided by twelve, free running even while the watchdog is off
   always_ff @(posedge tk.clk) begin
      if (tk.srst) begin
         div_q <= '0;
      end else if (tk.ce) begin
         if (div_q == DIV_W'(MC_DIV - 1)) begin
            div_q <= '0; // R2
         end else begin
            div_q <= div_q + 1'b1;
         end
      end
   end

   assign tk.mc_tick = tk.ce & (div_q == DIV_W'(MC_DIV - 1)); // R2

   // prescaler held clear while the watchdog is off
   always_ff @(posedge tk.clk) begin
      if (tk.srst) begin
         pre_q <= '0; // R18
      end else if (tk.ce) begin
         if (!tk.run) begin
            pre_q <= '0;
         end else if (tk.mc_tick) begin
            pre_q <= pre_q + 1'b1; // R1
         end
      end
   end

   // one strobe per full prescaler wrap
   assign tk.wrap_tick = tk.mc_tick & tk.run & (&pre_q); // R3

   property p_mc_div;
      @(posedge tk.clk) disable iff (tk.srst)
      tk.mc_tick |=> (div_q == '0);
   endproperty
   a_mc_div: assert property (p_mc_div) else $error("machine tick not followed by restart"); // R2

   property p_wrap;
      @(posedge tk.clk) disable iff (tk.srst)
      tk.wrap_tick |=> (pre_q == '0);
   endproperty
   a_wrap: assert property (p_wrap) else $error("prescaler did not wrap on counter tick"); // R3
endmodule

// [logic/wdt_pulse.sv]
// stretches a watchdog overflow into the reset pin pulse
// assumes fire is a one cycle strobe from the core
`include "wdt_regs.svh"

module wdt_pulse #(
   parameter int MC_DIV = `WDT_MC_DIV,
   parameter int PULSE_MC = `WDT_PULSE_MC
) (
   // tick carrier
   wdt_tick_if.pulse tk
);
   import wdt_pkg::*;

   localparam int PULSE_CYC = PULSE_MC * MC_DIV;
   localparam int N_W = $clog2(PULSE_CYC + 1);

   if (PULSE_MC < 1 || MC_DIV < 2) begin : g_chk
      $error("wdt_pulse: PULSE_MC must be at least 1 and MC_DIV at least 2");
   end

   pulse_state_t state_q;
   logic [N_W-1:0] n_q;
   logic drive_q;

   // counts oscillator periods, so the width does not depend on tick alignment
   always_ff @(posedge tk.clk) begin
      if (tk.srst) begin
         state_q <= PL_IDLE;
         n_q <= '0;
         drive_q <= 1'b0;
      end else if (tk.ce) begin
         case (state_q)
            PL_IDLE: begin
               if (tk.fire) begin
                  state_q <= PL_DRIVE;
                  n_q <= '0;
                  drive_q <= 1'b1; // R5
               end
            end
            PL_DRIVE: begin
               if (n_q == N_W'(PULSE_CYC - 1)) begin
                  state_q <= PL_DONE;
                  drive_q <= 1'b0; // R5
               end else begin
                  n_q <= n_q + 1'b1;
               end
            end
            PL_DONE: begin
               state_q <= PL_IDLE;
            end
            default: begin
               state_q <= PL_IDLE;
               drive_q <= 1'b0;
            end
         endcase
      end
   end

   assign tk.drive = drive_q;

   property p_pulse_len;
      @(posedge tk.clk) disable iff (tk.srst)
      $fell(drive_q) |-> $past(n_q) == N_W'(PULSE_CYC - 1);
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("reset pin pulse has wrong width"); // R5

   property p_pulse_start;
      @(posedge tk.clk) disable iff (tk.srst)
      $rose(drive_q) |-> $past(tk.fire);
   endproperty
   a_pulse_start: assert property (p_pulse_start) else $error("reset pin pulse without overflow"); // R5
endmodule

// [logic/wdt_core.sv]
// watchdog core: apb register slave, reload lock, counter and overflow reset
// assumes apb signals and the enable pin are synchronous to CLK
//
// Function
// [R1] 8-bit counter fed by 11-bit prescaler
// [R2] prescaler steps at oscillator over twelve
// [R3] counter steps once per prescaler wrap
// [R4] overflow gives short internal chip reset
// [R5] overflow drives three machine cycle pin pulse
// [R6] low enable pin turns watchdog on
// [R7] software cannot stop an enabled watchdog
// [R8] software reloads before the interval elapses
// [R9] reload needs unlock flag set first
// [R10] loading the counter clears unlock flag
// [R11] counter writes ignored while flag clear
// [R12] counter counts up from reload value
// [R13] watchdog keeps running in idle mode
// [R14] power-down bit blocked, reads zero when enabled
// [R15] high enable pin means no overflow reset
// [R16] counter at index FF, power control 87
// [R17] software sets unlock at scattered places
// [R18] chip reset clears flag, prescaler, counter
//
// Our own choice: register access over APB.
`include "wdt_regs.svh"

module wdt_core #(
   parameter int CNT_W = `WDT_CNT_W,
   parameter int PRE_W = `WDT_PRE_W,
   parameter int MC_DIV = `WDT_MC_DIV,
   parameter int PULSE_MC = `WDT_PULSE_MC,
   parameter int ADDR_W = 12
) (
   // clock, reset, clock enable
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire wdt_pkg::apb_word_t PWDATA,
   input wire logic [3:0] PSTRB,
   output wdt_pkg::apb_word_t PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // watchdog enable pin, active low
   input wire logic WATCHDOG_ENABLE_PIN_N,
   // reset pin drive, active high pulse
   output logic RST_PIN_O,
   output logic RST_PIN_OE,
   // chip side
   output logic CHIP_RST,
   output logic IDLE_REQ,
   output logic PDOWN_REQ
);
   import wdt_pkg::*;

   if (CNT_W < 1 || CNT_W > 8 || ADDR_W < 10 || ADDR_W > 32) begin : g_chk
      $error("wdt_core: CNT_W must be 1..8 and ADDR_W 10..32");
   end

   // byte addresses are four times the register index
   localparam logic [ADDR_W-1:0] ADDR_COUNT = ADDR_W'({`WDT_IDX_COUNT, 2'b00});
   localparam logic [ADDR_W-1:0] ADDR_PWR = ADDR_W'({`WDT_IDX_PWR_CTL, 2'b00});
   localparam logic [CNT_W-1:0] COUNT_RST = CNT_W'(`WDT_COUNT_RST);
   localparam reg_byte_t PWR_RST = `WDT_PWR_RST;

   wdt_tick_if tick (
      .clk(CLK),
      .srst(SRST)
   );

   logic enabled;
   logic access;
   logic setup;
   logic hit_count;
   logic hit_pwr;
   logic mapped;
   logic wr_en;
   logic load_count;
   logic overflow;
   logic [CNT_W-1:0] count_q;
   logic unlock_q;
   logic pd_q;
   logic idle_q;
   logic chip_rst_q;
   reg_byte_t pwr_rd;
   reg_byte_t rdata_d;
   apb_word_t prdata_q;

   // enable pin is the only way in or out of watchdog operation
   assign enabled = ~WATCHDOG_ENABLE_PIN_N; // R6 R7 R15

   // apb decode; the slave never inserts wait states but honours the freeze
   assign setup = PSEL & ~PENABLE;
   assign access = PSEL & PENABLE;
   assign hit_count = PADDR == ADDR_COUNT; // R16
   assign hit_pwr = PADDR == ADDR_PWR; // R16
   assign mapped = hit_count | hit_pwr;
   assign wr_en = CE & access & PWRITE & PSTRB[0] & mapped;
   assign PREADY = CE;
   assign PSLVERR = access & ~mapped;

   // a counter write only lands while the unlock flag is up
   assign load_count = wr_en & hit_count & unlock_q; // R9 R11

   // reload wins over an overflow in the same cycle, avoiding a needless chip reset
   assign overflow = enabled & tick.wrap_tick & (&count_q) & ~load_count; // R4 R15

   // prescaler runs whenever enabled, idle does not gate it
   assign tick.ce = CE;
   assign tick.run = enabled; // R13
   assign tick.fire = overflow; // R5

   wdt_prescale #(
      .MC_DIV(MC_DIV),
      .PRE_W(PRE_W)
   ) u_prescale (
      .tk(tick.pre)
   );

   wdt_pulse #(
      .MC_DIV(MC_DIV),
      .PULSE_MC(PULSE_MC)
   ) u_pulse (
      .tk(tick.pulse)
   );

   // watchdog counter, an up counter so a small reload gives a long interval
   always_ff @(posedge CLK) begin
      if (SRST) begin
         count_q <= COUNT_RST; // R18
      end else if (CE) begin
         if (load_count) begin
            count_q <= PWDATA[CNT_W-1:0]; // R9
         end else if (tick.wrap_tick) begin
            count_q <= count_q + 1'b1; // R1 R3 R12
         end
      end
   end

   // unlock flag: set by software, dropped by hardware once the counter loads
   always_ff @(posedge CLK) begin
      if (SRST) begin
         unlock_q <= PWR_RST[`WDT_PWR_UNLOCK_BIT]; // R18
      end else if (CE) begin
         if (wr_en & hit_pwr) begin
            unlock_q <= PWDATA[`WDT_PWR_UNLOCK_BIT]; // R9
         end else if (load_count) begin
            unlock_q <= 1'b0; // R10
         end
      end
   end

   // power-down request cannot be raised while the watchdog is on
   always_ff @(posedge CLK) begin
      if (SRST) begin
         pd_q <= PWR_RST[`WDT_PWR_PD_BIT];
      end else if (CE) begin
         if (wr_en & hit_pwr) begin
            pd_q <= PWDATA[`WDT_PWR_PD_BIT] & ~enabled; // R14
         end else if (enabled) begin
            pd_q <= 1'b0; // R14
         end
      end
   end

   // idle request, passed to the chip; the watchdog ignores it
   always_ff @(posedge CLK) begin
      if (SRST) begin
         idle_q <= PWR_RST[`WDT_PWR_IDLE_BIT];
      end else if (CE) begin
         if (wr_en & hit_pwr) begin
            idle_q <= PWDATA[`WDT_PWR_IDLE_BIT];
         end
      end
   end

   // one cycle internal reset strobe; do not loop it straight into SRST here
   always_ff @(posedge CLK) begin
      if (SRST) begin
         chip_rst_q <= 1'b0;
      end else if (CE) begin
         chip_rst_q <= overflow; // R4
      end
   end

   // power control readback, unused bits read zero
   always_comb begin
      pwr_rd = '0;
      pwr_rd[`WDT_PWR_UNLOCK_BIT] = unlock_q;
      pwr_rd[`WDT_PWR_PD_BIT] = pd_q; // R14
      pwr_rd[`WDT_PWR_IDLE_BIT] = idle_q;
   end

   // read mux
   always_comb begin
      rdata_d = '0;
      if (hit_count) begin
         rdata_d = reg_byte_t'(count_q);
      end else if (hit_pwr) begin
         rdata_d = pwr_rd;
      end
   end

   // read data caught in the setup cycle so PRDATA is a flop during access
   always_ff @(posedge CLK) begin
      if (SRST) begin
         prdata_q <= '0;
      end else if (CE && setup && !PWRITE) begin
         prdata_q <= {24'h000000, rdata_d};
      end
   end

   assign PRDATA = prdata_q;
   assign RST_PIN_O = tick.drive; // R5
   assign RST_PIN_OE = tick.drive;
   assign CHIP_RST = chip_rst_q;
   assign IDLE_REQ = idle_q;
   assign PDOWN_REQ = pd_q;

   property p_load;
      @(posedge CLK) disable iff (SRST)
      load_count |=> (count_q == $past(PWDATA[CNT_W-1:0])) && !unlock_q;
   endproperty
   a_load: assert property (p_load) else $error("unlocked reload not taken"); // R10

   property p_locked;
      @(posedge CLK) disable iff (SRST)
      (wr_en && hit_count && !unlock_q && !tick.wrap_tick) |=> $stable(count_q);
   endproperty
   a_locked: assert property (p_locked) else $error("locked counter write changed count"); // R11

   property p_unlock_set;
      @(posedge CLK) disable iff (SRST)
      (wr_en && hit_pwr) |=> unlock_q == $past(PWDATA[`WDT_PWR_UNLOCK_BIT]);
   endproperty
   a_unlock_set: assert property (p_unlock_set) else $error("unlock flag write lost"); // R9

   property p_pd_blocked;
      @(posedge CLK) disable iff (SRST)
      (CE && enabled) |=> !pd_q && !PDOWN_REQ;
   endproperty
   a_pd_blocked: assert property (p_pd_blocked) else $error("power-down set while enabled"); // R14

   property p_no_fire_off;
      @(posedge CLK) disable iff (SRST)
      (CE && !enabled) |=> !CHIP_RST;
   endproperty
   a_no_fire_off: assert property (p_no_fire_off) else $error("reset while watchdog off"); // R15

   property p_ovf;
      @(posedge CLK) disable iff (SRST)
      (CE && enabled && tick.wrap_tick && (&count_q) && !load_count)
         |=> CHIP_RST && (count_q == '0) ##1 RST_PIN_OE;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow did not reset chip"); // R4

   property p_count_up;
      @(posedge CLK) disable iff (SRST)
      (CE && tick.wrap_tick && !load_count) |=> count_q == CNT_W'($past(count_q) + 1'b1);
   endproperty
   a_count_up: assert property (p_count_up) else $error("counter did not step up"); // R12

   property p_idle_runs;
      @(posedge CLK) disable iff (SRST)
      (CE && enabled && idle_q && tick.mc_tick && !load_count && (&count_q) && tick.wrap_tick)
         |=> CHIP_RST;
   endproperty
   a_idle_runs: assert property (p_idle_runs) else $error("watchdog stalled in idle"); // R13

   property p_slverr;
      @(posedge CLK) disable iff (SRST)
      (access && !mapped) |-> PSLVERR && PREADY == CE;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not flagged"); // R16
endmodule

// [bench/tb.sv]
// self-checking bench for wdt_core: apb registers, reload lock, overflow reset pulse
// assumes the design files and wdt_pkg are compiled ahead of this file
`include "wdt_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
   $display("[ERR] %0t got %0h want %0h", $time, (a), (b)); end end

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import wdt_pkg::*;
   // shortened counts: one counter step is sixteen clocks
   localparam int PRE_W = 3;
   localparam int MC_DIV = 2;
   localparam int STEP = MC_DIV * (2 ** PRE_W);
   localparam int PW = `WDT_PULSE_MC * MC_DIV;
   localparam logic [11:0] A_CNT = {2'h0, `WDT_IDX_COUNT, 2'h0};
   localparam logic [11:0] A_PC = {2'h0, `WDT_IDX_PWR_CTL, 2'h0};
   localparam logic [11:0] A_BAD = 12'h100;
   logic CLK = 1'b0;
   logic SRST = 1'b1;
   logic CE = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [11:0] PADDR = 12'h000;
   apb_word_t PWDATA = 32'h0;
   logic [3:0] PSTRB = 4'h0;
   logic WATCHDOG_ENABLE_PIN_N = 1'b1;
   apb_word_t PRDATA;
   logic PREADY, PSLVERR, RST_PIN_O, RST_PIN_OE, CHIP_RST, IDLE_REQ, PDOWN_REQ;
   int n_fail = 0;
   int n_tests = 0;
   int seed = 32'hDB16;
   int n;
   int k;
   logic [7:0] v;
   logic [33:0] q[$];
   logic [33:0] e;

   wdt_core #(.PRE_W(PRE_W), .MC_DIV(MC_DIV)) u_wdt_core (
      .CLK(CLK), .SRST(SRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .WATCHDOG_ENABLE_PIN_N(WATCHDOG_ENABLE_PIN_N),
      .RST_PIN_O(RST_PIN_O), .RST_PIN_OE(RST_PIN_OE),
      .CHIP_RST(CHIP_RST), .IDLE_REQ(IDLE_REQ), .PDOWN_REQ(PDOWN_REQ)
   );

   // 200 MHz clock
   initial begin
      forever #2.5 CLK = ~CLK;
   end

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // one apb transfer; entered just after a rising edge, notes the expected answer
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] st, input logic [7:0] x, input logic err);
      int i;
      q.push_back({~wr, err, 24'h0, x});
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= {24'h0, d};
      PSTRB <= st;
      @(posedge CLK);
      PENABLE <= 1'b1;
      i = 0;
      do begin
         @(posedge CLK);
         i++;
      end while (PREADY !== 1'b1 && i < 50);
      if (i >= 50) begin
         n_fail++;
         $display("[ERR] %0t no ready", $time);
         end_of_test();
      end
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      // a spare edge so the next setup never lands in this time step
      @(posedge CLK);
   endtask

   // waits on falling edges for the chip reset strobe, bounded
   task automatic wait_fire(input int lim, output int cnt);
      cnt = 0;
      while (CHIP_RST !== 1'b1 && cnt < lim) begin
         @(negedge CLK);
         cnt++;
      end
      if (cnt >= lim) begin
         n_fail++;
         $display("[ERR] %0t no overflow reset", $time);
         end_of_test();
      end
   endtask

   // answer monitor: oldest note against each completed access
   always @(posedge CLK) begin
      if (PSEL && PENABLE && PREADY) begin
         e = (q.size() > 0) ? q.pop_front() : 34'h3FFFFFFFF;
         `CHK(PSLVERR, e[32])
         if (e[33]) `CHK(PRDATA, e[31:0])
      end
   end

   // main sequence
   initial begin
      repeat (2) @(posedge CLK);
      SRST <= 1'b0;
      apb(1'b0, A_CNT, 8'h00, 4'hF, 8'h00, 1'b0);
      apb(1'b0, A_PC, 8'h00, 4'hF, 8'h00, 1'b0);
      apb(1'b1, A_BAD, 8'h55, 4'hF, 8'h00, 1'b1);
      apb(1'b0, A_BAD, 8'h00, 4'hF, 8'h00, 1'b1);
      apb(1'b1, A_CNT, 8'h5A, 4'hF, 8'h00, 1'b0);
      apb(1'b0, A_CNT, 8'h00, 4'hF, 8'h00, 1'b0);
      $display("test reset and lock done");
      // watchdog off: two step reload, strobe gating, power-down allowed
      apb(1'b1, A_PC, 8'h10, 4'hF, 8'h00, 1'b0);
      apb(1'b1, A_CNT, 8'h5A, 4'hF, 8'h00, 1'b0);
      apb(1'b0, A_CNT, 8'h00, 4'hF, 8'h5A, 1'b0);
      apb(1'b0, A_PC, 8'h00, 4'hF, 8'h00, 1'b0);
      apb(1'b1, A_PC, 8'h10, 4'hE, 8'h00, 1'b0);
      apb(1'b0, A_PC, 8'h00, 4'hF, 8'h00, 1'b0);
      apb(1'b1, A_PC, 8'h12, 4'hF, 8'h00, 1'b0);
      apb(1'b0, A_PC, 8'h00, 4'hF, 8'h12, 1'b0);
      apb(1'b1, A_CNT, 8'hFF, 4'hF, 8'h00, 1'b0);
      k = 0;
      repeat (10 * STEP) begin
         @(negedge CLK);
         if (CHIP_RST === 1'b1) k++;
      end
      `CHK(k, 0)
      `CHK(PDOWN_REQ, 1'b1)
      $display("test disabled done");
      // enable with the counter at its top: overflow, strobe and pin pulse
      @(posedge CLK);
      WATCHDOG_ENABLE_PIN_N <= 1'b0;
      wait_fire(STEP + 8, n);
      k = 0;
      while (RST_PIN_OE === 1'b1 && k < 50) begin
         @(negedge CLK);
         k++;
         if (k == 1) `CHK(CHIP_RST, 1'b0)
         if (k == 1) `CHK(RST_PIN_O, 1'b1)
      end
      `CHK(k, PW)
      `CHK(PDOWN_REQ, 1'b0)
      @(posedge CLK);
      WATCHDOG_ENABLE_PIN_N <= 1'b1;
      @(posedge CLK);
      apb(1'b0, A_CNT, 8'h00, 4'hF, 8'h00, 1'b0);
      $display("test overflow done");
      // watchdog on: power-down refused, idle kept, random reloads near the top
      WATCHDOG_ENABLE_PIN_N <= 1'b0;
      apb(1'b1, A_PC, 8'h13, 4'hF, 8'h00, 1'b0);
      apb(1'b0, A_PC, 8'h00, 4'hF, 8'h11, 1'b0);
      `CHK(IDLE_REQ, 1'b1)
      `CHK(PDOWN_REQ, 1'b0)
      for (int i = 0; i < 3; i++) begin
         v = 8'hF8 | 8'($random(seed));
         apb(1'b1, A_PC, 8'h00, 4'hF, 8'h00, 1'b0);
         apb(1'b1, A_PC, 8'h11, 4'hF, 8'h00, 1'b0);
         apb(1'b1, A_CNT, v, 4'hF, 8'h00, 1'b0);
         wait_fire((256 - int'(v)) * STEP + 8, n);
         `CHK(n > (255 - int'(v)) * STEP - 8, 1'b1)
         repeat (PW + 2) @(negedge CLK);
         @(posedge CLK);
      end
      $display("test enabled done");
      end_of_test();
   end
endmodule
